/* File: tb/cmb_byte_sink.sv */
// Byte consumer standing in for the bus side of the frame sender.
`timescale 1ns/1ps
module cmb_byte_sink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic clr,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  output logic byteReady
);
  // ==========================================================================
  // Capture of offered bytes.
  logic [7:0] got [0:7];
  logic [3:0] numGot;
  logic sawLast;
  // Ready toggles in slow mode so that every byte after the first sees a stall.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      byteReady <= 1'b0;
    end else begin
      byteReady <= slow ? !byteReady : 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst || clr) begin
      numGot <= 4'h0;
      sawLast <= 1'b0;
    end else if (byteValid && byteReady) begin
      got[numGot[2:0]] <= byteData;
      numGot <= numGot + 4'h1;
      sawLast <= byteLast;
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking testbench for the message buffer store.
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Stimulus values.
  localparam logic [10:0] SID = 11'h5a3;
  localparam logic [17:0] EID = 18'h2abcd;
  localparam logic [63:0] PAY = 64'h8877665544332211;
  localparam logic [10:0] RSID = 11'h13c;
  localparam logic [17:0] REID = 18'h1f0f3;
  localparam logic [63:0] RDAT = 64'h0102030405060708;
  localparam logic [15:0] ROW_IN [8] = '{16'hffff, 16'hffff, 16'hfeef,
    16'ha55a, 16'h3cc3, 16'h0ff0, 16'hf00f, 16'hffff};
  localparam logic [15:0] ROW_OUT [8] = '{16'h1fff, 16'h0fff, 16'hfe0f,
    16'ha55a, 16'h3cc3, 16'h0ff0, 16'hf00f, 16'h1f00};
  localparam logic [3:0] DLCS [4] = '{4'h3, 4'h9, 4'h0, 4'h8};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] bufDirSel = 4'h1;
  logic dmaReq = 1'b0;
  logic dmaWe = 1'b0;
  logic [4:0] dmaAddr = 5'h00;
  logic [15:0] dmaWdata = 16'h0000;
  logic [15:0] dmaRdata;
  logic dmaAck, txFrameValid, txIde, txSrr, txRtr, txByteValid;
  logic txByteLast, txByteReady, txDone, txBusy, rxAck, rxAccepted;
  logic txStart = 1'b0;
  logic [1:0] txBuf = 2'h0;
  logic [10:0] txStdId;
  logic [17:0] txExtId;
  logic [3:0] txDlc;
  logic [7:0] txByte;
  logic rxStore = 1'b0;
  logic [1:0] rxBuf = 2'h0;
  logic [10:0] rxStdId = RSID;
  logic [17:0] rxExtId = REID;
  logic rxIde = 1'b1;
  logic rxSrr = 1'b0;
  logic rxRtr = 1'b0;
  logic [3:0] rxDlc = 4'h5;
  logic [63:0] rxData = RDAT;
  logic [4:0] rxFilter = 5'h00;
  logic slow = 1'b0;
  logic clr = 1'b0;
  int num_errors = 0;
  int checked = 0;
  always #50 clk = ~clk;
  cmb_msg_buffer cmb_msg_buffer_inst (.clk, .nrst, .bufDirSel, .dmaReq,
    .dmaWe, .dmaAddr, .dmaWdata, .dmaRdata, .dmaAck, .txStart, .txBuf,
    .txFrameValid, .txStdId, .txExtId, .txIde, .txSrr, .txRtr, .txDlc,
    .txByteValid, .txByte, .txByteLast, .txByteReady, .txDone, .txBusy,
    .rxStore, .rxBuf, .rxStdId, .rxExtId, .rxIde, .rxSrr, .rxRtr, .rxDlc,
    .rxData, .rxFilter, .rxAck, .rxAccepted);
  cmb_byte_sink cmb_byte_sink_inst (.clk, .nrst, .slow, .clr,
    .byteValid(txByteValid), .byteData(txByte), .byteLast(txByteLast),
    .byteReady(txByteReady));
  // ==========================================================================
  // Shared tasks.
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic dmaAccess(input logic we, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    dmaReq = 1'b1;
    dmaWe = we;
    dmaAddr = a;
    dmaWdata = d;
    @(negedge clk);
    dmaReq = 1'b0;
    dmaWe = 1'b0;
    check(dmaAck, 1'b1);
    q = dmaRdata;
  endtask
  task automatic sendFrame(input logic ide, input logic [3:0] dlc,
    input logic isSlow);
    int n;
    int k;
    logic [15:0] q;
    n = (dlc > 4'h8) ? 8 : int'(dlc);
    slow = isSlow;
    dmaAccess(1'b1, 5'h00, {3'h0, SID, 1'b1, ide}, q);
    dmaAccess(1'b1, 5'h01, {4'h0, EID[17:6]}, q);
    dmaAccess(1'b1, 5'h02, {EID[5:0], 1'b1, 1'b0, 3'h0, 1'b0, dlc}, q);
    @(negedge clk);
    clr = 1'b1;
    txStart = 1'b1;
    txBuf = 2'h0;
    @(negedge clk);
    clr = 1'b0;
    txStart = 1'b0;
    check(txFrameValid, 1'b1);
    check(txStdId, SID);
    check(txExtId, ide ? EID : 18'h0);
    check({txIde, txSrr, txRtr}, {ide, 2'b11});
    check(txDlc, dlc);
    k = 0;
    while (txDone !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check(txDone, 1'b1);
    check(cmb_byte_sink_inst.numGot, n);
    for (k = 0; k < n; k++) begin
      check(cmb_byte_sink_inst.got[k], PAY[8*k +: 8]);
    end
    check(cmb_byte_sink_inst.sawLast, n > 0);
  endtask
  task automatic storeFrame(input logic [1:0] b);
    @(negedge clk);
    rxStore = 1'b1;
    rxBuf = b;
    rxFilter = 5'h15;
    @(negedge clk);
    rxStore = 1'b0;
    check(rxAck, 1'b1);
    check(rxAccepted, !bufDirSel[b]);
  endtask
  function automatic logic [15:0] rxWord(input int w);
    case (w)
      0: rxWord = {3'h0, RSID, 1'b0, 1'b1};
      1: rxWord = {4'h0, REID[17:6]};
      2: rxWord = {REID[5:0], 1'b0, 1'b0, 3'h0, 1'b0, 4'h5};
      7: rxWord = {3'h0, 5'h15, 8'h00};
      default: rxWord = RDAT[16*(w-3) +: 16];
    endcase
  endfunction
  // ==========================================================================
  // Watchdog.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    summarize();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [15:0] v;
    int i;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check({dmaAck, txFrameValid, txBusy, txDone, rxAck}, 5'h00);
    for (i = 0; i < 8; i++) begin
      dmaAccess(1'b0, {2'h2, 3'(i)}, 16'h0000, v);
      check(v, 16'h0000);
    end
    for (i = 0; i < 8; i++) begin
      dmaAccess(1'b1, {2'h2, 3'(i)}, ROW_IN[i], v);
    end
    for (i = 0; i < 8; i++) begin
      dmaAccess(1'b0, {2'h2, 3'(i)}, 16'h0000, v);
      check(v, ROW_OUT[i]);
    end
    for (i = 0; i < 4; i++) begin
      dmaAccess(1'b1, {2'h0, 3'(i + 3)}, PAY[16*i +: 16], v);
    end
    for (i = 0; i < 4; i++) begin
      sendFrame(i[0] == 1'b0, DLCS[i], i[0]);
    end
    @(negedge clk);
    txStart = 1'b1;
    txBuf = 2'h1;
    @(negedge clk);
    txStart = 1'b0;
    check(txFrameValid, 1'b0);
    repeat (2) @(negedge clk);
    check({txBusy, txByteValid}, 2'b00);
    storeFrame(2'h1);
    for (i = 0; i < 8; i++) begin
      dmaAccess(1'b0, {2'h1, 3'(i)}, 16'h0000, v);
      check(v, rxWord(i));
    end
    dmaAccess(1'b1, 5'h07, 16'h0a00, v);
    storeFrame(2'h0);
    dmaAccess(1'b0, 5'h07, 16'h0000, v);
    check(v, 16'h0a00);
    dmaAccess(1'b0, 5'h00, 16'h0000, v);
    check(v, {3'h0, SID, 1'b1, 1'b0});
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check({dmaAck, txFrameValid, txBusy, txDone, rxAck}, 5'h00);
    dmaAccess(1'b0, 5'h08, 16'h0000, v);
    check(v, 16'h0000);
    summarize();
  end
endmodule

/* File: verilog/cmb_byte_sender.sv */
// Sends the payload bytes of one frame in ascending order.
`timescale 1ns/1ps
module cmb_byte_sender (
  input wire logic clk,
  input wire logic nrst,
  cmb_tx_if.ser tx
);
  cmb_pkg::cmb_ser_state_e state;
  logic [63:0] pay;
  logic [3:0] cnt;
  logic [3:0] sent;
  logic [3:0] nxtSent;
  logic [5:0] nxtPos;

  assign nxtSent = sent + 4'h1;
  assign nxtPos = {nxtSent[2:0], 3'h0};

  // ==========================================================================
  // Sequencing.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= cmb_pkg::SER_IDLE;
      pay <= 64'h0;
      cnt <= 4'h0;
      sent <= 4'h0;
      tx.busy <= 1'b0;
      tx.byteValid <= 1'b0;
      tx.byteData <= 8'h00;
      tx.byteLast <= 1'b0;
      tx.done <= 1'b0;
    end else begin
      tx.done <= 1'b0;
      case (state)
        cmb_pkg::SER_IDLE: begin
          if (tx.load) begin
            pay <= tx.payload;
            cnt <= tx.count;
            sent <= 4'h0;
            tx.byteData <= tx.payload[7:0];
            tx.byteLast <= (tx.count == 4'h1);
            if (tx.count != 4'h0) begin
              state <= cmb_pkg::SER_SEND;
              tx.busy <= 1'b1;
              tx.byteValid <= 1'b1;
            end else begin
              tx.done <= 1'b1;
            end
          end
        end
        cmb_pkg::SER_SEND: begin
          if (tx.byteReady) begin
            sent <= nxtSent;
            tx.byteData <= pay[nxtPos +: 8];
            tx.byteLast <= (nxtSent + 4'h1 == cnt);
            if (nxtSent == cnt) begin
              state <= cmb_pkg::SER_IDLE;
              tx.busy <= 1'b0;
              tx.byteValid <= 1'b0;
              tx.done <= 1'b1;
            end
          end
        end
        default: begin
          state <= cmb_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_lastTaken;
    tx.byteValid && tx.byteReady && tx.byteLast;
  endsequence
  property p_last_ends;
    @(posedge clk) disable iff (!nrst)
    s_lastTaken |=> !tx.byteValid && tx.done && (sent == cnt);
  endproperty
  a_last_ends: assert property (p_last_ends)
    else $error("frame did not end after last byte");
  property p_first_byte;
    @(posedge clk) disable iff (!nrst)
    tx.load && !tx.busy && (tx.count != 4'h0) |=>
      tx.byteValid && (tx.byteData == $past(tx.payload[7:0]));
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("first byte is not byte zero");
endmodule

/* File: verilog/cmb_msg_buffer.sv */
// Message buffer store with word access, frame fetch and frame store.
`timescale 1ns/1ps
module cmb_msg_buffer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] bufDirSel,
  input wire logic dmaReq,
  input wire logic dmaWe,
  input wire logic [4:0] dmaAddr,
  input wire logic [15:0] dmaWdata,
  output logic [15:0] dmaRdata,
  output logic dmaAck,
  input wire logic txStart,
  input wire logic [1:0] txBuf,
  output logic txFrameValid,
  output logic [10:0] txStdId,
  output logic [17:0] txExtId,
  output logic txIde,
  output logic txSrr,
  output logic txRtr,
  output logic [3:0] txDlc,
  output logic txByteValid,
  output logic [7:0] txByte,
  output logic txByteLast,
  input wire logic txByteReady,
  output logic txDone,
  output logic txBusy,
  input wire logic rxStore,
  input wire logic [1:0] rxBuf,
  input wire logic [10:0] rxStdId,
  input wire logic [17:0] rxExtId,
  input wire logic rxIde,
  input wire logic rxSrr,
  input wire logic rxRtr,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  input wire logic [4:0] rxFilter,
  output logic rxAck,
  output logic rxAccepted
);
  logic [15:0] memWords [cmb_pkg::NUM_ENTRY];
  logic [15:0] rxWord [cmb_pkg::WORDS_PER_BUF];
  logic [15:0] maskedWdata;
  logic dmaWrEn;
  logic rxWrEn;
  logic txAccept;
  logic loadPending;
  logic [15:0] txW0;
  logic [15:0] txW1;
  logic [15:0] txW2;
  logic [3:0] txLen;
  logic [1:0] rxBufQ;
  logic [15:0] w7Before;

  cmb_tx_if txIf ();

  // ==========================================================================
  // Word masking on the DMA write path.
  cmb_word_mask u_mask (
    .wordIdx(dmaAddr[2:0]),
    .dataIn(dmaWdata),
    .dataOut(maskedWdata)
  );

  // ==========================================================================
  // Byte sender.
  cmb_byte_sender u_sender (
    .clk(clk),
    .nrst(nrst),
    .tx(txIf)
  );

  assign txBusy = txIf.busy;
  assign txByteValid = txIf.byteValid;
  assign txByte = txIf.byteData;
  assign txByteLast = txIf.byteLast;
  assign txDone = txIf.done;
  assign txIf.byteReady = txByteReady;

  // ==========================================================================
  // Frame store word images.
  assign rxWrEn = rxStore && !bufDirSel[rxBuf];

  always_comb begin
    for (int w = 0; w < cmb_pkg::WORDS_PER_BUF; w++) begin
      rxWord[w] = cmb_pkg::WORD_RESET;
    end
    rxWord[cmb_pkg::W_STD][cmb_pkg::SID_MSB:cmb_pkg::SID_LSB] = rxStdId;
    rxWord[cmb_pkg::W_STD][cmb_pkg::SRR_BIT] = rxSrr;
    rxWord[cmb_pkg::W_STD][cmb_pkg::IDE_BIT] = rxIde;
    rxWord[cmb_pkg::W_EXTH][cmb_pkg::EIDH_MSB:cmb_pkg::EIDH_LSB] =
      rxExtId[17:cmb_pkg::EID_SPLIT];
    rxWord[cmb_pkg::W_EXTL][cmb_pkg::EIDL_MSB:cmb_pkg::EIDL_LSB] =
      rxExtId[cmb_pkg::EID_SPLIT-1:0];
    rxWord[cmb_pkg::W_EXTL][cmb_pkg::RTR_BIT] = rxRtr;
    rxWord[cmb_pkg::W_EXTL][cmb_pkg::RES_HI_BIT] = 1'b0;
    rxWord[cmb_pkg::W_EXTL][cmb_pkg::RES_LO_BIT] = 1'b0;
    rxWord[cmb_pkg::W_EXTL][cmb_pkg::DLC_MSB:cmb_pkg::DLC_LSB] = rxDlc;
    for (int k = 0; k < 4; k++) begin
      rxWord[int'(cmb_pkg::W_PAY0) + k][cmb_pkg::LO_BYTE_LSB +: 8] =
        rxData[16*k +: 8];
      rxWord[int'(cmb_pkg::W_PAY0) + k][cmb_pkg::HI_BYTE_LSB +: 8] =
        rxData[16*k+8 +: 8];
    end
    rxWord[cmb_pkg::W_FILT][cmb_pkg::FILT_MSB:cmb_pkg::FILT_LSB] =
      rxFilter;
  end

  // ==========================================================================
  // Buffer storage, one flip-flop word per entry.
  assign dmaWrEn = dmaReq && dmaWe;

  for (genvar e = 0; e < cmb_pkg::NUM_ENTRY; e++) begin : g_entry
    localparam logic [4:0] IDX = 5'(e);
    always_ff @(posedge clk) begin
      if (!nrst) begin
        memWords[e] <= cmb_pkg::WORD_RESET;
      end else if (rxWrEn && rxBuf == IDX[4:3]) begin
        memWords[e] <= rxWord[IDX[2:0]];
      end else if (dmaWrEn && dmaAddr == IDX) begin
        memWords[e] <= maskedWdata;
      end
    end
  end

  // ==========================================================================
  // DMA word access.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dmaAck <= 1'b0;
      dmaRdata <= 16'h0000;
    end else begin
      dmaAck <= dmaReq;
      if (dmaReq && !dmaWe) begin
        dmaRdata <= memWords[dmaAddr];
      end
    end
  end

  // ==========================================================================
  // Frame store answer.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxAck <= 1'b0;
      rxAccepted <= 1'b0;
    end else begin
      rxAck <= rxStore;
      rxAccepted <= rxWrEn;
    end
  end

  // ==========================================================================
  // Frame fetch.
  assign txW0 = memWords[{txBuf, cmb_pkg::W_STD}];
  assign txW1 = memWords[{txBuf, cmb_pkg::W_EXTH}];
  assign txW2 = memWords[{txBuf, cmb_pkg::W_EXTL}];
  assign txLen = (txW2[cmb_pkg::DLC_MSB:cmb_pkg::DLC_LSB] > cmb_pkg::MAX_BYTES)
    ? cmb_pkg::MAX_BYTES : txW2[cmb_pkg::DLC_MSB:cmb_pkg::DLC_LSB];
  assign txAccept = txStart && bufDirSel[txBuf] && !txIf.busy
    && !loadPending;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txFrameValid <= 1'b0;
      txStdId <= 11'h000;
      txExtId <= 18'h00000;
      txIde <= 1'b0;
      txSrr <= 1'b0;
      txRtr <= 1'b0;
      txDlc <= 4'h0;
    end else begin
      txFrameValid <= txAccept;
      if (txAccept) begin
        txStdId <= txW0[cmb_pkg::SID_MSB:cmb_pkg::SID_LSB];
        txSrr <= txW0[cmb_pkg::SRR_BIT];
        txIde <= txW0[cmb_pkg::IDE_BIT];
        txRtr <= txW2[cmb_pkg::RTR_BIT];
        txDlc <= txW2[cmb_pkg::DLC_MSB:cmb_pkg::DLC_LSB];
        if (txW0[cmb_pkg::IDE_BIT]) begin
          txExtId <= {txW1[cmb_pkg::EIDH_MSB:cmb_pkg::EIDH_LSB],
            txW2[cmb_pkg::EIDL_MSB:cmb_pkg::EIDL_LSB]};
        end else begin
          txExtId <= 18'h00000;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      loadPending <= 1'b0;
      txIf.load <= 1'b0;
      txIf.payload <= 64'h0;
      txIf.count <= 4'h0;
    end else begin
      loadPending <= txAccept;
      txIf.load <= txAccept;
      if (txAccept) begin
        txIf.payload <= {memWords[{txBuf, cmb_pkg::W_PAY3}],
          memWords[{txBuf, cmb_pkg::W_PAY2}],
          memWords[{txBuf, cmb_pkg::W_PAY1}],
          memWords[{txBuf, cmb_pkg::W_PAY0}]};
        txIf.count <= txLen;
      end
    end
  end

  // ==========================================================================
  // Checks.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxBufQ <= 2'h0;
      w7Before <= 16'h0000;
    end else begin
      rxBufQ <= rxBuf;
      w7Before <= memWords[{rxBuf, cmb_pkg::W_FILT}];
    end
  end

  sequence s_readWord(logic [2:0] w);
    dmaReq && !dmaWe && (dmaAddr[2:0] == w);
  endsequence

  property p_rd_std;
    @(posedge clk) disable iff (!nrst)
    s_readWord(cmb_pkg::W_STD) |=> dmaAck && (dmaRdata[15:13] == 3'h0);
  endproperty
  a_rd_std: assert property (p_rd_std)
    else $error("word 0 upper bits not zero");

  property p_rd_exth;
    @(posedge clk) disable iff (!nrst)
    s_readWord(cmb_pkg::W_EXTH) |=> dmaRdata[15:12] == 4'h0;
  endproperty
  a_rd_exth: assert property (p_rd_exth)
    else $error("word 1 upper bits not zero");

  property p_rd_extl;
    @(posedge clk) disable iff (!nrst)
    s_readWord(cmb_pkg::W_EXTL) |=> dmaRdata[7:5] == 3'h0;
  endproperty
  a_rd_extl: assert property (p_rd_extl)
    else $error("word 2 bits 7 to 5 not zero");

  property p_rd_filt;
    @(posedge clk) disable iff (!nrst)
    s_readWord(cmb_pkg::W_FILT) |=>
      (dmaRdata[15:13] == 3'h0) && (dmaRdata[7:0] == 8'h00);
  endproperty
  a_rd_filt: assert property (p_rd_filt)
    else $error("word 7 unimplemented bits not zero");

  property p_rx_fields;
    @(posedge clk) disable iff (!nrst)
    rxWrEn |=> rxAccepted
      && (memWords[{rxBufQ, cmb_pkg::W_FILT}][12:8] == $past(rxFilter))
      && (memWords[{rxBufQ, cmb_pkg::W_STD}][1] == $past(rxSrr))
      && (memWords[{rxBufQ, cmb_pkg::W_EXTL}][9] == $past(rxRtr));
  endproperty
  a_rx_fields: assert property (p_rx_fields)
    else $error("stored frame fields wrong");

  property p_rx_payload;
    @(posedge clk) disable iff (!nrst)
    rxWrEn |=> memWords[{rxBufQ, cmb_pkg::W_PAY0}] ==
      {$past(rxData[15:8]), $past(rxData[7:0])};
  endproperty
  a_rx_payload: assert property (p_rx_payload)
    else $error("payload byte order wrong");

  property p_tx_buf_kept;
    @(posedge clk) disable iff (!nrst)
    rxStore && bufDirSel[rxBuf] && !dmaWrEn |=> !rxAccepted
      && (memWords[{rxBufQ, cmb_pkg::W_FILT}] == w7Before);
  endproperty
  a_tx_buf_kept: assert property (p_tx_buf_kept)
    else $error("transmit buffer filter field changed");

  property p_std_only;
    @(posedge clk) disable iff (!nrst)
    txFrameValid && !txIde |-> txExtId == 18'h00000;
  endproperty
  a_std_only: assert property (p_std_only)
    else $error("extended identifier sent in standard frame");

  property p_tx_dir;
    @(posedge clk) disable iff (!nrst)
    txStart && !bufDirSel[txBuf] |=> !txFrameValid;
  endproperty
  a_tx_dir: assert property (p_tx_dir)
    else $error("receive buffer was transmitted");

  property p_tx_len;
    @(posedge clk) disable iff (!nrst)
    txFrameValid |-> txIf.load && (txIf.count ==
      ((txDlc > 4'h8) ? 4'h8 : txDlc));
  endproperty
  a_tx_len: assert property (p_tx_len)
    else $error("byte count does not follow length code");
endmodule

/* File: verilog/cmb_pkg.sv */
// Constants and types shared by the message buffer store and its helpers.
package cmb_pkg;
  // ==========================================================================
  // Buffer geometry.
  localparam int NUM_BUF = 4;
  localparam int WORDS_PER_BUF = 8;
  localparam int NUM_ENTRY = NUM_BUF * WORDS_PER_BUF;
  localparam int BUF_W = 2;
  localparam int WORD_W = 3;
  localparam int ADDR_W = BUF_W + WORD_W;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ==========================================================================
  // Word positions inside one buffer.
  localparam logic [2:0] W_STD = 3'h0;
  localparam logic [2:0] W_EXTH = 3'h1;
  localparam logic [2:0] W_EXTL = 3'h2;
  localparam logic [2:0] W_PAY0 = 3'h3;
  localparam logic [2:0] W_PAY1 = 3'h4;
  localparam logic [2:0] W_PAY2 = 3'h5;
  localparam logic [2:0] W_PAY3 = 3'h6;
  localparam logic [2:0] W_FILT = 3'h7;
  // ==========================================================================
  // Implemented bits of each word.
  localparam logic [15:0] MASK_STD = 16'h1fff;
  localparam logic [15:0] MASK_EXTH = 16'h0fff;
  localparam logic [15:0] MASK_EXTL = 16'hff1f;
  localparam logic [15:0] MASK_PAY = 16'hffff;
  localparam logic [15:0] MASK_FILT = 16'h1f00;
  // ==========================================================================
  // Field positions.
  localparam int SID_MSB = 12;
  localparam int SID_LSB = 2;
  localparam int SRR_BIT = 1;
  localparam int IDE_BIT = 0;
  localparam int EIDH_MSB = 11;
  localparam int EIDH_LSB = 0;
  localparam int EIDL_MSB = 15;
  localparam int EIDL_LSB = 10;
  localparam int EID_SPLIT = 6;
  localparam int RTR_BIT = 9;
  localparam int RES_HI_BIT = 8;
  localparam int RES_LO_BIT = 4;
  localparam int DLC_MSB = 3;
  localparam int DLC_LSB = 0;
  localparam int LO_BYTE_LSB = 0;
  localparam int HI_BYTE_LSB = 8;
  localparam int FILT_MSB = 12;
  localparam int FILT_LSB = 8;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  // ==========================================================================
  // Byte sender states.
  typedef enum logic {SER_IDLE, SER_SEND} cmb_ser_state_e;
endpackage

/* File: verilog/cmb_tx_if.sv */
// Carrier between the buffer store and its byte sender.
`timescale 1ns/1ps
interface cmb_tx_if;
  logic load;
  logic [63:0] payload;
  logic [3:0] count;
  logic busy;
  logic byteValid;
  logic [7:0] byteData;
  logic byteLast;
  logic byteReady;
  logic done;
  modport ser (
    input load, payload, count, byteReady,
    output busy, byteValid, byteData, byteLast, done
  );
  modport ctl (
    output load, payload, count, byteReady,
    input busy, byteValid, byteData, byteLast, done
  );
endinterface

/* File: verilog/cmb_word_mask.sv */
// Clears the unimplemented bits of a buffer word by its position.
`timescale 1ns/1ps
module cmb_word_mask (
  input wire logic [2:0] wordIdx,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut
);
  logic [15:0] mask;

  // ==========================================================================
  // Mask selection.
  always_comb begin
    case (wordIdx)
      cmb_pkg::W_STD: mask = cmb_pkg::MASK_STD;
      cmb_pkg::W_EXTH: mask = cmb_pkg::MASK_EXTH;
      cmb_pkg::W_EXTL: mask = cmb_pkg::MASK_EXTL;
      cmb_pkg::W_FILT: mask = cmb_pkg::MASK_FILT;
      default: mask = cmb_pkg::MASK_PAY;
    endcase
  end

  assign dataOut = dataIn & mask;
endmodule
